// [logic/abx_pkg.sv]
// Purpose: shared constants and types of the arithmetic and branch execute block
// Assumes: one clock, four clocks per instruction cycle
// Notes:   offsets are byte addresses on the register bus
package abx_pkg;
   // =====================================================
   // widths
   localparam int PC_W = 21;
   localparam int FA_W = 12;

   // =====================================================
   // register offsets
   localparam logic [4:0] OFS_CTRL  = 5'h00;
   localparam logic [4:0] OFS_ACCUM = 5'h04;
   localparam logic [4:0] OFS_STAT  = 5'h08;
   localparam logic [4:0] OFS_BANK  = 5'h0C;
   localparam logic [4:0] OFS_PC    = 5'h10;
   localparam logic [4:0] OFS_INFO  = 5'h14;

   // =====================================================
   // field positions
   localparam int CTRL_RUN = 0;
   localparam int CTRL_EXT = 1;
   localparam int STAT_C   = 0;
   localparam int STAT_DC  = 1;
   localparam int STAT_Z   = 2;
   localparam int STAT_OV  = 3;
   localparam int STAT_N   = 4;

   // =====================================================
   // reset values
   localparam logic [7:0]      RST_ACCUM = 8'h00;
   localparam logic [4:0]      RST_STAT  = 5'h00;
   localparam logic [3:0]      RST_BANK  = 4'h0;
   localparam logic [PC_W-1:0] RST_PC    = 21'h000000;
   localparam logic [15:0]     RST_INSTR = 16'h0000;

   // =====================================================
   // opcodes
   localparam logic [7:0] OPC_ADD_LIT  = 8'h0F;
   localparam logic [7:0] OPC_AND_LIT  = 8'h0B;
   localparam logic [5:0] OP6_ADDC     = 6'h08;
   localparam logic [5:0] OP6_ADD_FILE = 6'h09;
   localparam logic [5:0] OP6_AND_FILE = 6'h05;
   localparam logic [7:0] OPC_BR_C     = 8'hE2;
   localparam logic [7:0] OPC_BR_NC    = 8'hE3;
   localparam logic [7:0] OPC_BR_N     = 8'hE6;
   localparam logic [7:0] OPC_BR_NN    = 8'hE7;

   // =====================================================
   // addressing and timing
   localparam logic [7:0]      ACC_SPLIT = 8'h5F;
   localparam logic [3:0]      ACC_LO    = 4'h0;
   localparam logic [3:0]      ACC_HI    = 4'hF;
   localparam logic [PC_W-1:0] PC_STEP   = 21'h000002;
   localparam logic [1:0]      Q_LAST    = 2'h3;

   // =====================================================
   // types
   typedef enum logic {ST_RUN, ST_FLUSH} abx_state_t;

   typedef struct packed {
      abx_state_t      state;
      logic            run;
      logic            ext;
      logic [7:0]      accum;
      logic [4:0]      stat;
      logic [3:0]      bank;
      logic [PC_W-1:0] pc;
      logic [15:0]     instr;
      logic [FA_W-1:0] file_addr;
      logic            file_rd;
      logic            file_wr;
      logic [7:0]      file_wdata;
      logic            wait_r;
      logic [31:0]     rdata;
   } abx_core_t;

   typedef struct packed {
      logic [1:0] phase;
   } abx_qgen_t;
endpackage

// [logic/abx_core_if.sv]
// Purpose: links the core to its adder and its phase divider
// Assumes: all signals on the core clock
// Notes:   no storage here
`timescale 1ns/1ps
interface abx_core_if;
   logic [7:0] a;
   logic [7:0] b;
   logic       cin;
   logic       is_and;
   logic [7:0] res;
   logic       c_out;
   logic       dc;
   logic       z;
   logic       ov;
   logic       neg;
   logic       run;
   logic [1:0] phase;

   modport alu  (input a, b, cin, is_and, output res, c_out, dc, z, ov, neg);
   modport qgen (input run, output phase);
   modport core (output a, b, cin, is_and, run,
                 input res, c_out, dc, z, ov, neg, phase);
endinterface

// [logic/abx_alu.sv]
// Purpose: 8-bit add with carry in and bitwise and, with flag outputs
// Assumes: purely combinational
// Notes:   overflow is signed overflow of the add
`timescale 1ns/1ps
module abx_alu
   import abx_pkg::*;
(
   // operands and result
   abx_core_if.alu cif
);
   logic [8:0] sum;
   logic [4:0] low;

   // =====================================================
   // arithmetic
   always_comb begin
      sum = {1'b0, cif.a} + {1'b0, cif.b} + {8'h00, cif.cin};
      low = {1'b0, cif.a[3:0]} + {1'b0, cif.b[3:0]} + {4'h0, cif.cin};
      if (cif.is_and) begin
         cif.res = cif.a & cif.b;
      end else begin
         cif.res = sum[7:0];
      end
      cif.c_out = sum[8];
      cif.dc    = low[4];
      cif.ov    = (cif.a[7] == cif.b[7]) && (sum[7] != cif.a[7]);
      cif.z     = (cif.res == 8'h00);
      cif.neg   = cif.res[7];
   end
endmodule

// [logic/abx_qgen.sv]
// Purpose: divides the clock into the four phases of an instruction cycle
// Assumes: phase holds at zero while the core is stopped
// Notes:   phase 3 ends each instruction cycle
`timescale 1ns/1ps
module abx_qgen
   import abx_pkg::*;
(
   // clock and reset
   input  wire logic clk,
   input  wire logic reset_n,
   // phase link
   abx_core_if.qgen  cif
);
   abx_qgen_t s_r;
   abx_qgen_t s_nxt;

   // =====================================================
   // phase counter
   always_comb begin
      s_nxt = s_r;
      if (!cif.run) begin
         s_nxt.phase = 2'h0;
      end else begin
         s_nxt.phase = s_r.phase + 2'h1;
      end
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         s_r <= '0;
      end else begin
         s_r <= s_nxt;
      end
   end

   assign cif.phase = s_r.phase;

   // =====================================================
   // checks
   a_phase_wrap: assert property (@(posedge clk) disable iff (!reset_n)
      cif.run && s_r.phase == Q_LAST |=> s_r.phase == 2'h0)
      else $error("phase did not wrap after last phase");
endmodule

// [logic/abx_exec.sv]
// Purpose: decode and execute of add, and, and the carry and sign branches
// Assumes: program word valid within three clocks of prog_addr; file data one
//          clock after file_rd
// Notes:   one instruction cycle is four clocks
//
// Contract
// - add literal (high byte 0F) adds the literal into the accumulator and sets N OV C DC Z.
// - add with carry (0010 00da) adds accumulator, file and carry into the destination.
// - destination bit 0 writes the accumulator and 1 writes the file register.
// - access bit 0 selects the access bank and 1 forms the address from the bank selector.
// - access bit 0 with extended mode and operand up to 95 is an offset from the index.
// - branch on carry (E2) jumps only when carry is 1.
// - branch on negative (E6) jumps only when negative is 1.
// - branch unless carry (E3) jumps only when carry is 0.
// - branch unless negative (E7) jumps only when negative is 0.
// - a taken branch loads the address plus 2 plus twice the signed offset.
// - a branch takes one cycle, or two when taken with the second a no operation.
`timescale 1ns/1ps
module abx_exec
   import abx_pkg::*;
(
   // clock and reset
   input  wire logic            clk,
   input  wire logic            reset_n,
   // register bus
   input  wire logic [4:0]      avs_address,
   input  wire logic            avs_read,
   input  wire logic            avs_write,
   input  wire logic [31:0]     avs_writedata,
   output logic      [31:0]     avs_readdata,
   output logic                 avs_waitrequest,
   // program memory
   output logic      [PC_W-1:0] prog_addr,
   input  wire logic [15:0]     prog_data,
   // data file
   output logic      [FA_W-1:0] file_addr,
   output logic                 file_rd,
   input  wire logic [7:0]      file_rdata,
   output logic                 file_wr,
   output logic      [7:0]      file_wdata,
   input  wire logic [FA_W-1:0] index_base
);
   abx_core_t       s_r;
   abx_core_t       s_nxt;
   abx_core_if      cif ();
   logic [7:0]      op_hi;
   logic [5:0]      op6;
   logic            dst_bit;
   logic            acc_bit;
   logic [7:0]      lit;
   logic            is_add_lit;
   logic            is_and_lit;
   logic            is_addc;
   logic            is_add_file;
   logic            is_and_file;
   logic            is_file;
   logic            is_br;
   logic            br_take;
   logic            exec_q4;
   logic [FA_W-1:0] eff_addr;
   logic [31:0]     rd_val;

   // =====================================================
   // helpers
   abx_alu u_alu (
      .cif (cif.alu)
   );

   abx_qgen u_qgen (
      .clk     (clk),
      .reset_n (reset_n),
      .cif     (cif.qgen)
   );

   // =====================================================
   // decode
   always_comb begin
      op_hi       = s_r.instr[15:8];
      op6         = s_r.instr[15:10];
      dst_bit     = s_r.instr[9];
      acc_bit     = s_r.instr[8];
      lit         = s_r.instr[7:0];
      is_add_lit  = (op_hi == OPC_ADD_LIT);
      is_and_lit  = (op_hi == OPC_AND_LIT);
      is_addc     = (op6 == OP6_ADDC);
      is_add_file = (op6 == OP6_ADD_FILE);
      is_and_file = (op6 == OP6_AND_FILE);
      is_file     = is_addc || is_add_file || is_and_file;
      is_br       = 1'b1;
      br_take     = 1'b0;
      unique case (op_hi)
         OPC_BR_C:  br_take = s_r.stat[STAT_C];
         OPC_BR_N:  br_take = s_r.stat[STAT_N];
         OPC_BR_NC: br_take = !s_r.stat[STAT_C];
         OPC_BR_NN: br_take = !s_r.stat[STAT_N];
         default:   is_br = 1'b0;
      endcase
      exec_q4 = s_r.run && s_r.state == ST_RUN && cif.phase == Q_LAST;
   end

   // =====================================================
   // file address
   always_comb begin
      if (acc_bit) begin
         eff_addr = {s_r.bank, lit};
      end else if (s_r.ext && lit <= ACC_SPLIT) begin
         eff_addr = FA_W'(index_base + {4'h0, lit});
      end else if (lit <= ACC_SPLIT) begin
         eff_addr = {ACC_LO, lit};
      end else begin
         eff_addr = {ACC_HI, lit};
      end
   end

   // =====================================================
   // adder operands
   always_comb begin
      cif.a      = s_r.accum;
      cif.b      = is_file ? file_rdata : lit;
      cif.cin    = is_addc && s_r.stat[STAT_C];
      cif.is_and = is_and_lit || is_and_file;
      cif.run    = s_r.run;
   end

   // =====================================================
   // register read mux
   always_comb begin
      unique case (avs_address)
         OFS_CTRL:  rd_val = {30'h0, s_r.ext, s_r.run};
         OFS_ACCUM: rd_val = {24'h0, s_r.accum};
         OFS_STAT:  rd_val = {27'h0, s_r.stat};
         OFS_BANK:  rd_val = {28'h0, s_r.bank};
         OFS_PC:    rd_val = {11'h0, s_r.pc};
         OFS_INFO:  rd_val = {13'h0, s_r.state == ST_FLUSH, cif.phase, s_r.instr};
         default:   rd_val = 32'h0;
      endcase
   end

   // =====================================================
   // next state
   always_comb begin
      s_nxt         = s_r;
      s_nxt.file_rd = 1'b0;
      s_nxt.file_wr = 1'b0;
      // bus slave, write lands at the edge that sees the answer
      if (!s_r.wait_r) begin
         s_nxt.wait_r = 1'b1;
         if (avs_write) begin
            if (avs_address == OFS_CTRL) begin
               s_nxt.run = avs_writedata[CTRL_RUN];
               s_nxt.ext = avs_writedata[CTRL_EXT];
            end else if (!s_r.run) begin
               unique case (avs_address)
                  OFS_ACCUM: s_nxt.accum = avs_writedata[7:0];
                  OFS_STAT:  s_nxt.stat  = avs_writedata[4:0];
                  OFS_BANK:  s_nxt.bank  = avs_writedata[3:0];
                  OFS_PC:    s_nxt.pc    = avs_writedata[PC_W-1:0];
                  default:   s_nxt.run   = s_r.run;
               endcase
            end
         end
      end else if (avs_read || avs_write) begin
         s_nxt.wait_r = 1'b0;
         s_nxt.rdata  = rd_val;
      end
      if (!s_r.run) begin
         s_nxt.state = ST_RUN;
      end else begin
         unique case (cif.phase)
            2'h0: begin
               if (s_r.state == ST_RUN) begin
                  s_nxt.instr = prog_data;
                  s_nxt.pc    = s_r.pc + PC_STEP;
               end
            end
            2'h1: begin
               if (s_r.state == ST_RUN && is_file) begin
                  s_nxt.file_addr = eff_addr;
                  s_nxt.file_rd   = 1'b1;
               end
            end
            2'h2: begin
               s_nxt.file_wdata = s_r.file_wdata;
            end
            2'h3: begin
               if (s_r.state == ST_FLUSH) begin
                  s_nxt.state = ST_RUN;
               end else if (is_add_lit || is_and_lit || is_file) begin
                  if (is_file && dst_bit) begin
                     s_nxt.file_wr    = 1'b1;
                     s_nxt.file_wdata = cif.res;
                  end else begin
                     s_nxt.accum = cif.res;
                  end
                  s_nxt.stat[STAT_Z] = cif.z;
                  s_nxt.stat[STAT_N] = cif.neg;
                  if (!cif.is_and) begin
                     s_nxt.stat[STAT_C]  = cif.c_out;
                     s_nxt.stat[STAT_DC] = cif.dc;
                     s_nxt.stat[STAT_OV] = cif.ov;
                  end
               end else if (is_br && br_take) begin
                  s_nxt.pc    = s_r.pc + {{12{lit[7]}}, lit, 1'b0};
                  s_nxt.state = ST_FLUSH;
               end
            end
         endcase
      end
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         s_r            <= '0;
         s_r.state      <= ST_RUN;
         s_r.accum      <= RST_ACCUM;
         s_r.stat       <= RST_STAT;
         s_r.bank       <= RST_BANK;
         s_r.pc         <= RST_PC;
         s_r.instr      <= RST_INSTR;
         s_r.wait_r     <= 1'b1;
      end else begin
         s_r <= s_nxt;
      end
   end

   // =====================================================
   // outputs
   assign avs_readdata    = s_r.rdata;
   assign avs_waitrequest = s_r.wait_r;
   assign prog_addr       = s_r.pc;
   assign file_addr       = s_r.file_addr;
   assign file_rd         = s_r.file_rd;
   assign file_wr         = s_r.file_wr;
   assign file_wdata      = s_r.file_wdata;

   // =====================================================
   // checks
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!reset_n);

   sequence s_taken;
      exec_q4 && is_br && br_take;
   endsequence

   sequence s_flush;
      (s_r.state == ST_FLUSH && !s_r.file_rd && $stable(s_r.instr))[*4];
   endsequence

   a_add_lit_sum: assert property (
      exec_q4 && is_add_lit |=>
         s_r.accum == 8'($past(s_r.accum) + $past(lit)))
      else $error("add literal result wrong");

   a_addc_sum: assert property (
      exec_q4 && is_addc && !dst_bit |=>
         s_r.accum == 8'($past(s_r.accum) + $past(file_rdata)
                         + {7'h00, $past(s_r.stat[STAT_C])}))
      else $error("add with carry result wrong");

   a_dest_file: assert property (
      exec_q4 && is_file && dst_bit |=>
         s_r.file_wr && s_r.file_wdata == $past(cif.res) && $stable(s_r.accum))
      else $error("file destination not written");

   a_bank_addr: assert property (
      s_r.run && cif.phase == 2'h1 && s_r.state == ST_RUN && is_file && acc_bit |=>
         s_r.file_rd && s_r.file_addr == {s_r.bank, $past(lit)})
      else $error("banked address wrong");

   a_index_addr: assert property (
      s_r.run && cif.phase == 2'h1 && s_r.state == ST_RUN && is_file && !acc_bit
      && s_r.ext && lit <= ACC_SPLIT |=>
         s_r.file_addr == FA_W'($past(index_base) + {4'h0, $past(lit)}))
      else $error("indexed offset address wrong");

   a_br_hold: assert property (
      exec_q4 && is_br && !br_take |=> $stable(s_r.pc) && s_r.state == ST_RUN)
      else $error("untaken branch moved the counter");

   a_br_target: assert property (
      s_taken |=> s_r.pc == $past(s_r.pc) + {{12{$past(lit[7])}}, $past(lit), 1'b0})
      else $error("branch target wrong");

   a_br_flush: assert property (
      s_taken |=> ##1 ($stable(s_r.pc) && !s_r.file_wr)[*4])
      else $error("flush cycle fetched or wrote");

   a_flush_len: assert property (
      s_taken |=> s_flush ##1 (s_r.state == ST_RUN || !s_r.run))
      else $error("taken branch flush not four clocks of no operation");

   a_add_file: assert property (
      exec_q4 && is_add_file && !dst_bit |=>
         s_r.accum == 8'($past(s_r.accum) + $past(file_rdata))
         && s_r.stat[STAT_C] == $past(cif.c_out))
      else $error("add file result wrong");

   a_and_flags: assert property (
      exec_q4 && (is_and_lit || is_and_file) |=>
         s_r.stat[STAT_C] == $past(s_r.stat[STAT_C])
         && s_r.stat[STAT_OV] == $past(s_r.stat[STAT_OV])
         && s_r.stat[STAT_Z] == ($past(cif.res) == 8'h00))
      else $error("and changed arithmetic flags");

   a_bus_answer: assert property (
      (avs_read || avs_write) && s_r.wait_r |=> !s_r.wait_r ##1 s_r.wait_r)
      else $error("bus answer not one clock");
endmodule

// [verif/abx_exec_tb_top.sv]
// Purpose: self-checking bench of the add, and and branch execute block
// Assumes: bench plays program memory and data file behind the core
// Notes:   fixed-seed random instructions plus hand-picked corners
`timescale 1ns/1ps
`define CHECK(name, exp, got) \
   begin \
      comparisons++; \
      if ((got) !== (exp)) begin \
         num_errors++; \
         $display("MISMATCH %s expected %0h seen %0h", name, exp, got); \
      end \
   end

module abx_exec_tb_top
   import abx_pkg::*;
();
   // =====================================================
   // signals
   localparam logic [PC_W-1:0] A_BASE = 21'h001000;
   logic            clk;
   logic            reset_n;
   logic [4:0]      avs_address;
   logic            avs_read;
   logic            avs_write;
   logic [31:0]     avs_writedata;
   logic [31:0]     avs_readdata;
   logic            avs_waitrequest;
   logic [PC_W-1:0] prog_addr;
   logic [15:0]     prog_data;
   logic [FA_W-1:0] file_addr;
   logic            file_rd;
   logic [7:0]      file_rdata;
   logic            file_wr;
   logic [7:0]      file_wdata;
   logic [FA_W-1:0] index_base;
   logic [15:0]     pmem [logic [PC_W-1:0]];
   logic [7:0]      cur_fval;
   logic [FA_W-1:0] rd_addr;
   logic [FA_W-1:0] wr_addr;
   logic [7:0]      wr_data;
   logic [31:0]     got;
   logic [31:0]     r1;
   logic [31:0]     r2;
   logic [15:0]     ins;
   logic [7:0]      ops [9];
   int              rd_cnt;
   int              wr_cnt;
   int              num_errors;
   int              comparisons;
   int              seed;
   int              tnum;
   int              kind;
   int              cyc;
   int              pa_seen;
   logic [PC_W-1:0] pa_prev;

   abx_exec abx_exec_inst (
      .clk             (clk),
      .reset_n         (reset_n),
      .avs_address     (avs_address),
      .avs_read        (avs_read),
      .avs_write       (avs_write),
      .avs_writedata   (avs_writedata),
      .avs_readdata    (avs_readdata),
      .avs_waitrequest (avs_waitrequest),
      .prog_addr       (prog_addr),
      .prog_data       (prog_data),
      .file_addr       (file_addr),
      .file_rd         (file_rd),
      .file_rdata      (file_rdata),
      .file_wr         (file_wr),
      .file_wdata      (file_wdata),
      .index_base      (index_base)
   );

   // =====================================================
   // clock and memories
   initial clk = 1'h0;
   always #2.5 clk = ~clk;

   always @(posedge clk) begin
      // edge at which each new program address is first seen
      cyc++;
      if (prog_addr !== pa_prev) begin
         pa_seen = cyc;
      end
      pa_prev = prog_addr;
      prog_data <= pmem.exists(prog_addr) ? pmem[prog_addr] : 16'h0000;
      if (file_rd === 1'h1) begin
         file_rdata <= cur_fval;
         rd_addr = file_addr;
         rd_cnt++;
      end else if (!reset_n) begin
         file_rdata <= 8'h00;
      end else begin
         file_rdata <= ~file_rdata;
      end
      if (file_wr === 1'h1) begin
         wr_addr = file_addr;
         wr_data = file_wdata;
         wr_cnt++;
      end
   end

   // =====================================================
   // bus tasks
   task automatic bus_write(input logic [4:0] a, input logic [31:0] d);
      int n;
      n = 0;
      avs_address   <= a;
      avs_writedata <= d;
      avs_write     <= 1'h1;
      do begin
         @(posedge clk);
         n++;
      end while (avs_waitrequest !== 1'h0 && n < 64);
      avs_write <= 1'h0;
      @(posedge clk);
   endtask

   task automatic bus_read(input logic [4:0] a, output logic [31:0] d);
      int n;
      n = 0;
      avs_address <= a;
      avs_read    <= 1'h1;
      do begin
         @(posedge clk);
         n++;
      end while (avs_waitrequest !== 1'h0 && n < 64);
      d = avs_readdata;
      avs_read <= 1'h0;
      @(posedge clk);
   endtask

   // =====================================================
   // expected results
   function automatic logic [12:0] expect_alu(input logic [15:0] i, input logic [7:0] w,
                                              input logic [4:0] st, input logic [7:0] fv);
      logic [7:0] b;
      logic       cin;
      logic [8:0] s;
      logic [4:0] lo;
      logic [4:0] ns;
      b   = (i[15:12] == 4'h0) ? i[7:0] : fv;
      cin = (i[15:10] == OP6_ADDC) ? st[STAT_C] : 1'h0;
      s   = {1'h0, w} + {1'h0, b} + {8'h00, cin};
      lo  = {1'h0, w[3:0]} + {1'h0, b[3:0]} + {4'h0, cin};
      ns  = st;
      if (i[15:8] == OPC_AND_LIT || i[15:10] == OP6_AND_FILE) begin
         s = {1'h0, w & b};
      end else begin
         ns[STAT_C]  = s[8];
         ns[STAT_DC] = lo[4];
         ns[STAT_OV] = (w[7] == b[7]) && (s[7] != w[7]);
      end
      ns[STAT_Z] = (s[7:0] == 8'h00);
      ns[STAT_N] = s[7];
      return {ns, s[7:0]};
   endfunction

   // =====================================================
   // one instruction from a stopped core
   task automatic run_one(input logic [15:0] i, input logic [7:0] w, input logic [4:0] st,
                          input logic [3:0] bk, input logic ext, input logic [7:0] fv);
      logic [12:0]     alu;
      logic [PC_W-1:0] nxt;
      logic [FA_W-1:0] fa;
      logic [FA_W-1:0] ib;
      logic            fop;
      logic            br;
      logic            tk;
      int              n;
      int              t0;
      ib  = FA_W'($random(seed));
      fop = i[15:10] inside {OP6_ADDC, OP6_ADD_FILE, OP6_AND_FILE};
      br  = i[15:8] inside {OPC_BR_C, OPC_BR_NC, OPC_BR_N, OPC_BR_NN};
      tk  = (i[15:8] == OPC_BR_C && st[STAT_C]) || (i[15:8] == OPC_BR_NC && !st[STAT_C])
         || (i[15:8] == OPC_BR_N && st[STAT_N]) || (i[15:8] == OPC_BR_NN && !st[STAT_N]);
      nxt = A_BASE + PC_STEP + (tk ? {{12{i[7]}}, i[7:0], 1'h0} : 21'h000000);
      if (!i[8] && ext && i[7:0] <= ACC_SPLIT) begin
         fa = ib + {4'h0, i[7:0]};
      end else if (!i[8]) begin
         fa = {(i[7:0] <= ACC_SPLIT) ? ACC_LO : ACC_HI, i[7:0]};
      end else begin
         fa = {bk, i[7:0]};
      end
      alu = expect_alu(i, w, st, fv);
      pmem.delete();
      pmem[A_BASE] = i;
      cur_fval = fv;
      rd_cnt = 0;
      wr_cnt = 0;
      index_base <= ib;
      bus_write(OFS_ACCUM, {24'h000000, w});
      bus_write(OFS_STAT, {27'h0000000, st});
      bus_write(OFS_BANK, {28'h0000000, bk});
      bus_write(OFS_PC, {11'h000, A_BASE});
      bus_write(OFS_CTRL, {30'h00000000, ext, 1'h1});
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (prog_addr !== A_BASE + PC_STEP && n < 64);
      // one quiet edge so the change mark is settled
      @(posedge clk);
      t0 = pa_seen;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (prog_addr !== nxt + PC_STEP && n < 64);
      `CHECK("next pc", nxt + PC_STEP, prog_addr)
      @(posedge clk);
      `CHECK("cycles", (br && tk) ? 8 : 4, pa_seen - t0)
      bus_read(OFS_CTRL, got);
      `CHECK("ctrl", {30'h00000000, ext, 1'h1}, got)
      // ignored while running
      bus_write(OFS_ACCUM, {24'h000000, ~w});
      bus_write(OFS_CTRL, 32'h00000000);
      bus_read(OFS_ACCUM, got);
      `CHECK("accum", (br || (fop && i[9])) ? w : alu[7:0], got[7:0])
      bus_read(OFS_STAT, got);
      `CHECK("stat", br ? st : alu[12:8], got[4:0])
      `CHECK("reads", fop ? 1 : 0, rd_cnt)
      `CHECK("writes", (fop && i[9]) ? 1 : 0, wr_cnt)
      if (fop) begin
         `CHECK("read addr", fa, rd_addr)
      end
      if (fop && i[9]) begin
         `CHECK("write addr", fa, wr_addr)
         `CHECK("write data", alu[7:0], wr_data)
      end
      tnum++;
      $display("test %0d done, instruction %h", tnum, i);
   endtask

   // =====================================================
   // end of run
   task automatic stop_test;
      $display("comparisons %0d mismatches %0d", comparisons, num_errors);
      if (num_errors == 0 && comparisons > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask

   initial begin
      #100000;
      num_errors++;
      $display("MISMATCH watchdog expected finish seen timeout");
      stop_test();
   end

   // =====================================================
   // main sequence
   initial begin
      seed = 85;
      num_errors = 0;
      comparisons = 0;
      tnum = 0;
      rd_cnt = 0;
      wr_cnt = 0;
      reset_n = 1'h0;
      avs_address = 5'h00;
      avs_read = 1'h0;
      avs_write = 1'h0;
      avs_writedata = 32'h00000000;
      index_base = 12'h000;
      cur_fval = 8'h00;
      ops = '{OPC_ADD_LIT, OPC_AND_LIT, {OP6_ADDC, 2'h0}, {OP6_ADD_FILE, 2'h0},
              {OP6_AND_FILE, 2'h0}, OPC_BR_C, OPC_BR_NC, OPC_BR_N, OPC_BR_NN};
      repeat (5) @(posedge clk);
      reset_n <= 1'h1;
      @(posedge clk);
      `CHECK("reset prog_addr", RST_PC, prog_addr)
      bus_read(5'h18, got);
      `CHECK("unmapped read", 32'h00000000, got)
      bus_read(OFS_INFO, got);
      `CHECK("info after reset", 32'h00000000, got)
      run_one({OPC_ADD_LIT, 8'h01}, 8'h7F, 5'h00, 4'h3, 1'h0, 8'h00);
      run_one({OP6_ADDC, 2'h3, 8'h40}, 8'hFF, 5'h01, 4'h5, 1'h0, 8'h00);
      run_one({OP6_ADD_FILE, 2'h0, 8'h5F}, 8'h08, 5'h00, 4'h2, 1'h1, 8'h08);
      run_one({OP6_AND_FILE, 2'h2, 8'h60}, 8'hF0, 5'h1F, 4'h2, 1'h1, 8'h80);
      run_one({OPC_BR_NN, 8'h7F}, 8'h00, 5'h00, 4'h0, 1'h0, 8'h00);
      run_one({OPC_BR_C, 8'h80}, 8'h00, 5'h01, 4'h0, 1'h0, 8'h00);
      run_one({OPC_AND_LIT, 8'h00}, 8'hA5, 5'h0B, 4'h0, 1'h0, 8'h00);
      repeat (60) begin
         r1 = $random(seed);
         r2 = $random(seed);
         kind = int'(r2[31:26]) % 9;
         ins = r1[15:0];
         ins[15:8] = (kind >= 2 && kind <= 4) ? {ops[kind][7:2], r1[9:8]} : ops[kind];
         if (kind > 4 && ins[7:0] == 8'hFF) begin
            ins[0] = 1'h0;
         end
         run_one(ins, r2[7:0], r2[12:8], r2[16:13], r2[17], r2[25:18]);
      end
      stop_test();
   end
endmodule
